// file: hsp_consts.svh
`ifndef HSP_CONSTS_SVH
`define HSP_CONSTS_SVH

// carrier and refresh timing, in oscillator clocks
`define HSP_CARRIER_CYC   252
`define HSP_TRI_HALF      126
`define HSP_TRI_LAST      251
`define HSP_REFRESH_PCT   8
`define HSP_REFRESH_CYC   ((`HSP_CARRIER_CYC * `HSP_REFRESH_PCT) / 100)
`define HSP_TRI_CLAMP     (`HSP_TRI_HALF - (`HSP_REFRESH_CYC / 2))

// modulation waveform
`define HSP_STEPS         32
`define HSP_STEP_SHIFT    5
`define HSP_ANG_SPAN      192
`define HSP_ANG_THIRD     64
`define HSP_ANG_QUART     48
`define HSP_SINE_MID      256

// dead time in oscillator clocks
`define HSP_DT_SHORT      11
`define HSP_DT_LONG       16

// start-up threshold: longest 60 degree interval for sine drive
`define HSP_SLOW_LIMIT    131072
`define HSP_CNT_W         20

// register offsets
`define HSP_OFS_CTRL      8'h00
`define HSP_OFS_STATUS    8'h04
`define HSP_OFS_INTERVAL  8'h08

// control register fields
`define HSP_AMP_LSB       0
`define HSP_AMP_W         8
`define HSP_DIR_BIT       8
`define HSP_DTS_BIT       9
`define HSP_POL_BIT       10
`define HSP_CTRL_RST      32'h0000_0600

// status register fields
`define HSP_ST_BWD_BIT    0
`define HSP_ST_FAULT_BIT  1
`define HSP_ST_MODE_BIT   2
`define HSP_ST_HALL_LSB   4

// bus answers
`define HSP_RESP_OKAY     2'h0
`define HSP_RESP_DECERR   2'h3

`endif

// file: hsp_pkg.sv
package hsp_pkg;

  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } hsp_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } hsp_axi_rsp_t;

  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } hsp_gates_t;

  typedef enum logic {
    HSP_MODE_SQUARE = 1'b0,
    HSP_MODE_SINE   = 1'b1
  } hsp_mode_t;

  typedef enum logic [1:0] {
    HSP_PH_OFF  = 2'b00,
    HSP_PH_HIGH = 2'b01,
    HSP_PH_LOW  = 2'b10
  } hsp_drive_t;

endpackage

// file: hsp_phase_gate.sv
`timescale 1ns/1ps
module hsp_phase_gate import hsp_pkg::*; (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       hi_req_in,
  input  wire logic       lo_req_in,
  input  wire logic [4:0] dead_cyc_in,
  input  wire logic       pol_in,
  output logic            hi_out,
  output logic            lo_out
);

  logic       hi_on_q;
  logic       lo_on_q;
  logic [4:0] dt_q;
  wire        dt_done = (dt_q == 5'h00);
  wire        hi_drop = hi_on_q & ~hi_req_in;
  wire        lo_drop = lo_on_q & ~lo_req_in;
  // a side turns on only with the other side off and its request gone
  wire        hi_on_d = hi_on_q ? hi_req_in
                                : (hi_req_in & ~lo_req_in & ~lo_on_q & dt_done);
  wire        lo_on_d = lo_on_q ? lo_req_in
                                : (lo_req_in & ~hi_req_in & ~hi_on_q & dt_done);
  wire [4:0]  dt_d    = (hi_drop | lo_drop) ? dead_cyc_in
                                            : (dt_done ? 5'h00 : dt_q - 5'h01);

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hi_on_q <= 1'b0;
      lo_on_q <= 1'b0;
      dt_q    <= 5'h00;
      hi_out  <= 1'b0;
      lo_out  <= 1'b0;
    end else begin
      hi_on_q <= hi_on_d;
      lo_on_q <= lo_on_d;
      dt_q    <= dt_d;
      hi_out  <= pol_in ? hi_on_d : ~hi_on_d;
      lo_out  <= pol_in ? lo_on_d : ~lo_on_d;
    end
  end

endmodule // hsp_phase_gate

// file: hsp_modulator.sv
`timescale 1ns/1ps
`include "hsp_consts.svh"
module hsp_modulator import hsp_pkg::*; #(
  parameter int SLOW_LIMIT = `HSP_SLOW_LIMIT,
  parameter int CNT_W      = `HSP_CNT_W
) (
  input  wire logic   clk_in,
  input  wire logic   resetn_in,
  input  wire logic   hall_sense_a_in,
  input  wire logic   hall_sense_b_in,
  input  wire logic   hall_sense_c_in,
  input  hsp_axi_req_t axi_req_in,
  output hsp_axi_rsp_t axi_rsp_out,
  output hsp_gates_t   gates_out,
  output logic         backward_rotation_flag_out
);

  localparam int SW = CNT_W - `HSP_STEP_SHIFT;

  if (SLOW_LIMIT < 64 || SLOW_LIMIT >= (1 << CNT_W) || CNT_W > 30) begin : g_bad_param
    $error("hsp_modulator: SLOW_LIMIT does not fit CNT_W");
  end

  // quarter sine, 49 points, 1.875 degree apart, full scale 255
  localparam logic [7:0] SINE_Q [0:48] = '{
    8'h00, 8'h08, 8'h11, 8'h19, 8'h21, 8'h2a, 8'h32, 8'h3a, 8'h42, 8'h4a,
    8'h52, 8'h5a, 8'h62, 8'h69, 8'h71, 8'h78, 8'h80, 8'h87, 8'h8e, 8'h95,
    8'h9b, 8'ha2, 8'ha8, 8'hae, 8'hb4, 8'hba, 8'hc0, 8'hc5, 8'hca, 8'hcf,
    8'hd4, 8'hd8, 8'hdd, 8'he1, 8'he5, 8'he8, 8'hec, 8'hef, 8'hf1, 8'hf4,
    8'hf6, 8'hf8, 8'hfa, 8'hfc, 8'hfd, 8'hfe, 8'hfe, 8'hff, 8'hff
  };

  // forward sequence 001,011,010,110,100,101; 7 marks an invalid pattern
  function automatic logic [2:0] sector_of(input logic [2:0] h);
    case (h)
      3'b001:  sector_of = 3'd0;
      3'b011:  sector_of = 3'd1;
      3'b010:  sector_of = 3'd2;
      3'b110:  sector_of = 3'd3;
      3'b100:  sector_of = 3'd4;
      3'b101:  sector_of = 3'd5;
      default: sector_of = 3'd7;
    endcase
  endfunction

  function automatic logic [2:0] sector_next(input logic [2:0] s);
    sector_next = (s == 3'd5) ? 3'd0 : s + 3'd1;
  endfunction

  // six-step commutation, two phases conduct per sector
  function automatic hsp_drive_t commute(input logic [2:0] s, input int p);
    logic [2:0] hi_ph;
    logic [2:0] lo_ph;
    hi_ph = 3'd0;
    lo_ph = 3'd1;
    case (s)
      3'd0: begin hi_ph = 3'd0; lo_ph = 3'd1; end
      3'd1: begin hi_ph = 3'd0; lo_ph = 3'd2; end
      3'd2: begin hi_ph = 3'd1; lo_ph = 3'd2; end
      3'd3: begin hi_ph = 3'd1; lo_ph = 3'd0; end
      3'd4: begin hi_ph = 3'd2; lo_ph = 3'd0; end
      default: begin hi_ph = 3'd2; lo_ph = 3'd1; end
    endcase
    if (hi_ph == 3'(p))      commute = HSP_PH_HIGH;
    else if (lo_ph == 3'(p)) commute = HSP_PH_LOW;
    else                     commute = HSP_PH_OFF;
  endfunction

  // signed sine of an angle in 0..191
  function automatic logic signed [8:0] sine_of(input logic [7:0] a);
    logic [7:0] idx;
    logic       neg;
    idx = 8'h00;
    neg = 1'b0;
    if (a < 8'd48)       idx = a;
    else if (a < 8'd96)  idx = 8'd96 - a;
    else if (a < 8'd144) begin idx = a - 8'd96; neg = 1'b1; end
    else                 begin idx = 8'd192 - a; neg = 1'b1; end
    sine_of = neg ? -$signed({1'b0, SINE_Q[idx[5:0]]}) : $signed({1'b0, SINE_Q[idx[5:0]]});
  endfunction

  // compare level 0..116 around mid scale, capped below the refresh band
  function automatic logic [6:0] sine_level(input logic [7:0] a, input logic [7:0] amp);
    logic signed [17:0] prod;
    logic signed [17:0] lvl;
    prod = sine_of(a) * $signed({1'b0, amp});
    lvl  = (prod >>> 8) + 18'sd256;
    lvl  = lvl >>> 2;
    if (lvl > $signed(18'(`HSP_TRI_CLAMP))) sine_level = 7'(`HSP_TRI_CLAMP);
    else                           sine_level = lvl[6:0];
  endfunction

  function automatic logic [7:0] phase_ang(input logic [7:0] a, input int p);
    logic [8:0] s;
    s = {1'b0, a} + 9'(`HSP_ANG_SPAN) - 9'(`HSP_ANG_THIRD * p);
    if (s >= 9'(`HSP_ANG_SPAN)) s = s - 9'(`HSP_ANG_SPAN);
    phase_ang = s[7:0];
  endfunction

  // hall synchronisers
  logic [2:0]       hall_m_q;
  logic [2:0]       hall_s_q;
  logic [2:0]       hall_p_q;
  // interval timing
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] interval_q;
  logic [SW-1:0]    step_cnt_q;
  logic [4:0]       step_idx_q;
  logic             slow_q;
  logic             rot_rev_q;
  logic             bwd_q;
  hsp_mode_t        mode_q;
  // carrier
  logic [7:0]       car_q;
  // registers
  logic [31:0]      ctrl_q;

  wire [2:0] hall_now  = hall_s_q;
  wire       hall_edge = (hall_now != hall_p_q);
  wire [2:0] sec_new   = sector_of(hall_now);
  wire [2:0] sec_old   = sector_of(hall_p_q);
  wire       new_ok    = (sec_new != 3'd7);
  wire       old_ok    = (sec_old != 3'd7);
  wire       fault     = ~old_ok;
  wire       cnt_sat   = (cnt_q >= CNT_W'(SLOW_LIMIT));

  wire [7:0] amp      = ctrl_q[`HSP_AMP_LSB +: `HSP_AMP_W];
  wire       dir_sel  = ctrl_q[`HSP_DIR_BIT];
  wire       dts      = ctrl_q[`HSP_DTS_BIT];
  wire       pol      = ctrl_q[`HSP_POL_BIT];
  wire [4:0] dead_cyc = dts ? 5'(`HSP_DT_SHORT) : 5'(`HSP_DT_LONG);

  // step width is one thirty-second of the last interval
  wire [SW-1:0] step_w    = interval_q[CNT_W-1:`HSP_STEP_SHIFT];
  wire [SW-1:0] step_last = (step_w == '0) ? '0 : step_w - SW'(1);
  wire          step_end  = (step_cnt_q >= step_last);

  // direction of travel judged from each valid sector change
  wire fwd_move  = old_ok & new_ok & (sector_next(sec_old) == sec_new);
  wire rev_move  = old_ok & new_ok & (sector_next(sec_new) == sec_old);
  wire rot_rev_d = fwd_move ? 1'b0 : (rev_move ? 1'b1 : rot_rev_q);
  // reset and fault patterns must not fake a fast first interval
  wire slow_d    = (fwd_move | rev_move) ? cnt_sat : (slow_q | cnt_sat);
  wire bwd_d     = slow_d | (rot_rev_d != dir_sel);

  // carrier triangle 0..125..0 over 252 clocks
  wire       car_wrap = (car_q == 8'(`HSP_TRI_LAST));
  wire [6:0] tri_v    = (car_q < 8'(`HSP_TRI_HALF)) ? car_q[6:0]
                                                    : 7'(8'(`HSP_TRI_LAST) - car_q);
  // top of the triangle is the refresh band, 20 of 252 clocks
  wire       refresh  = (tri_v >= 7'(`HSP_TRI_CLAMP));

  // waveform angle: sector base plus step, walking backwards in reverse
  wire [4:0] step_dir = dir_sel ? ~step_idx_q : step_idx_q;
  wire [7:0] ang      = {sec_old, step_dir};
  wire [2:0] sq_sec   = dir_sel ? ((sec_old >= 3'd3) ? sec_old - 3'd3 : sec_old + 3'd3)
                                : sec_old;
  // high side stops dead+1 clocks ahead of the band, so the band stays whole
  wire [6:0] on_cap   = 7'(`HSP_TRI_CLAMP) - {2'b00, dead_cyc} - 7'h01;
  wire [6:0] sq_lvl   = (amp[7:1] > on_cap) ? on_cap : amp[7:1];

  logic [2:0] hi_req;
  logic [2:0] lo_req;
  logic [2:0] gate_hi;
  logic [2:0] gate_lo;

  for (genvar p = 0; p < 3; p++) begin : g_phase
    wire [6:0]  lvl    = sine_level(phase_ang(ang, p), amp);
    wire        hi_sin = (tri_v < lvl) & (tri_v < on_cap);
    hsp_drive_t drv;
    assign drv = commute(sq_sec, p);
    wire        hi_sq  = (drv == HSP_PH_HIGH) & (tri_v < sq_lvl);
    // low side refreshed in every carrier cycle, also on idle phases
    wire        lo_sq  = (drv == HSP_PH_LOW) | refresh;
    wire        sine   = (mode_q == HSP_MODE_SINE);
    // sine drive is complementary, which is 180 degree conduction
    assign hi_req[p] = ~fault & (sine ? hi_sin : hi_sq);
    assign lo_req[p] = ~fault & (sine ? ~hi_sin : lo_sq);

    hsp_phase_gate u_gate (
      .clk_in      (clk_in),
      .resetn_in   (resetn_in),
      .hi_req_in   (hi_req[p]),
      .lo_req_in   (lo_req[p]),
      .dead_cyc_in (dead_cyc),
      .pol_in      (pol),
      .hi_out      (gate_hi[p]),
      .lo_out      (gate_lo[p])
    );
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hall_m_q <= 3'h0;
      hall_s_q <= 3'h0;
      hall_p_q <= 3'h0;
    end else begin
      hall_m_q <= {hall_sense_c_in, hall_sense_b_in, hall_sense_a_in};
      hall_s_q <= hall_m_q;
      hall_p_q <= hall_s_q;
    end
  end

  // interval counter saturates at the start-up limit
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q      <= '0;
      interval_q <= '0;
    end else if (hall_edge) begin
      interval_q <= cnt_q;
      cnt_q      <= '0;
    end else if (!cnt_sat) begin
      cnt_q      <= cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      step_cnt_q <= '0;
      step_idx_q <= 5'h00;
    end else if (hall_edge) begin
      step_cnt_q <= '0;
      step_idx_q <= 5'h00;
    end else if (step_end) begin
      step_cnt_q <= '0;
      step_idx_q <= step_idx_q + 5'h01;
    end else begin
      step_cnt_q <= step_cnt_q + SW'(1);
    end
  end

  // flag starts high, so the motor always starts on square drive
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      slow_q    <= 1'b1;
      rot_rev_q <= 1'b0;
      bwd_q     <= 1'b1;
      mode_q    <= HSP_MODE_SQUARE;
    end else begin
      slow_q    <= slow_d;
      rot_rev_q <= rot_rev_d;
      bwd_q     <= bwd_d;
      mode_q    <= bwd_d ? HSP_MODE_SQUARE : HSP_MODE_SINE;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      car_q <= 8'h00;
    end else begin
      car_q <= car_wrap ? 8'h00 : car_q + 8'h01;
    end
  end

  // register slave: one write and one read under way at a time
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        aw_got_q;
  logic        w_got_q;
  logic [7:0]  waddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  wire aw_fire   = axi_req_in.awvalid & awready_q;
  wire w_fire    = axi_req_in.wvalid & wready_q;
  wire do_wr     = aw_got_q & w_got_q & ~bvalid_q;
  wire aw_got_d  = (aw_got_q | aw_fire) & ~do_wr;
  wire w_got_d   = (w_got_q | w_fire) & ~do_wr;
  wire bvalid_d  = bvalid_q ? ~axi_req_in.bready : do_wr;
  wire wr_ctrl   = do_wr & (waddr_q == `HSP_OFS_CTRL);
  wire wr_mapped = (waddr_q == `HSP_OFS_CTRL) | (waddr_q == `HSP_OFS_STATUS)
                 | (waddr_q == `HSP_OFS_INTERVAL);

  wire ar_fire  = axi_req_in.arvalid & arready_q;
  wire rvalid_d = rvalid_q ? ~axi_req_in.rready : ar_fire;
  wire [7:0] raddr = {axi_req_in.araddr[7:2], 2'b00};

  wire [31:0] status_w = 32'({hall_p_q, 1'b0, mode_q, fault, bwd_q});
  wire        rd_ctrl  = (raddr == `HSP_OFS_CTRL);
  wire        rd_stat  = (raddr == `HSP_OFS_STATUS);
  wire        rd_intv  = (raddr == `HSP_OFS_INTERVAL);
  wire        rd_hit   = rd_ctrl | rd_stat | rd_intv;
  wire [31:0] rd_mux   = rd_ctrl ? ctrl_q
                       : rd_stat ? status_w
                       : rd_intv ? 32'(interval_q) : 32'h0000_0000;

  // ctrl keeps only its used bits; the rest read as zero
  wire [31:0] ctrl_mask = 32'h0000_07ff;
  logic [31:0] ctrl_wr;
  always_comb begin
    ctrl_wr = ctrl_q;
    for (int b = 0; b < 4; b++) begin
      if (wstrb_q[b]) ctrl_wr[8*b +: 8] = wdata_q[8*b +: 8];
    end
    ctrl_wr = ctrl_wr & ctrl_mask;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `HSP_RESP_OKAY;
      waddr_q   <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      ctrl_q    <= `HSP_CTRL_RST;
    end else begin
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      awready_q <= ~aw_got_d & ~bvalid_d;
      wready_q  <= ~w_got_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
      if (aw_fire) waddr_q <= {axi_req_in.awaddr[7:2], 2'b00};
      if (w_fire) begin
        wdata_q <= axi_req_in.wdata;
        wstrb_q <= axi_req_in.wstrb;
      end
      if (do_wr) bresp_q <= wr_mapped ? `HSP_RESP_OKAY : `HSP_RESP_DECERR;
      if (wr_ctrl) ctrl_q <= ctrl_wr;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `HSP_RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_fire) begin
        rdata_q <= rd_mux;
        rresp_q <= rd_hit ? `HSP_RESP_OKAY : `HSP_RESP_DECERR;
      end
    end
  end

  assign axi_rsp_out.awready   = awready_q;
  assign axi_rsp_out.wready    = wready_q;
  assign axi_rsp_out.bvalid    = bvalid_q;
  assign axi_rsp_out.bresp     = bresp_q;
  assign axi_rsp_out.arready   = arready_q;
  assign axi_rsp_out.rvalid    = rvalid_q;
  assign axi_rsp_out.rdata     = rdata_q;
  assign axi_rsp_out.rresp     = rresp_q;
  assign gates_out.high        = gate_hi;
  assign gates_out.low         = gate_lo;
  assign backward_rotation_flag_out = bwd_q;

endmodule // hsp_modulator

// file: hsp_mod_checker.sv
`timescale 1ns/1ps
module hsp_mod_checker import hsp_pkg::*; #(
  parameter int SLOW_LIMIT = 131072,
  parameter int CNT_W      = 20
) (
  input  wire logic   clk_in,
  input  wire logic   resetn_in,
  input  wire logic   hall_sense_a_in,
  input  wire logic   hall_sense_b_in,
  input  wire logic   hall_sense_c_in,
  input  hsp_axi_req_t axi_req_in,
  input  hsp_axi_rsp_t axi_rsp_out,
  input  hsp_gates_t   gates_out,
  input  wire logic   backward_rotation_flag_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wire [2:0] hall = {hall_sense_c_in, hall_sense_b_in, hall_sense_a_in};
  wire       aw_tk = axi_req_in.awvalid & axi_rsp_out.awready;
  wire       w_tk = axi_req_in.wvalid & axi_rsp_out.wready;
  wire       ar_tk = axi_req_in.arvalid & axi_rsp_out.arready;
  wire       ar_bad = axi_req_in.araddr[7:2] > 6'h02;
  wire       ctl_wr = aw_tk & w_tk & (axi_req_in.awaddr[7:2] == 6'h00) & axi_req_in.wstrb[1];
  logic       pol_q, dts_q;
  logic [2:0] settle_q, hall_q, lo_prev_q;
  logic [5:0] bad_q;
  logic [9:0] quiet_q;
  logic [4:0] gap_q [3];
  // polarity tracked from bus writes; the design is not probed inside
  wire [5:0] act = pol_q ? {gates_out.high, gates_out.low} : ~{gates_out.high, gates_out.low};
  wire [2:0] hi_a = act[5:3];
  wire [2:0] lo_a = act[2:0];
  wire       all_lo = &lo_a;
  wire       bad = (hall == 3'h0) | (hall == 3'h7);
  wire [4:0] dead = dts_q ? 5'h0b : 5'h10;
  wire [2:0] short_gap;
  for (genvar i = 0; i < 3; i++) begin : g_gap
    assign short_gap[i] = lo_a[i] & ~lo_prev_q[i] & (gap_q[i] < dead);
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pol_q <= 1'b1; dts_q <= 1'b1; settle_q <= 3'h0; hall_q <= 3'h0;
      lo_prev_q <= 3'h0; bad_q <= 6'h00; quiet_q <= 10'h000;
      for (int i = 0; i < 3; i++) gap_q[i] <= 5'h1f;
    end else begin
      if (ctl_wr) begin
        pol_q <= axi_req_in.wdata[10];
        dts_q <= axi_req_in.wdata[9];
      end
      settle_q <= ctl_wr ? 3'h7 : settle_q - {2'h0, settle_q != 3'h0};
      bad_q <= !bad ? 6'h00 : bad_q + {5'h00, bad_q != 6'h3f};
      quiet_q <= (hall != hall_q || ctl_wr) ? 10'h000 : quiet_q + {9'h000, quiet_q != 10'h3ff};
      hall_q <= hall;
      lo_prev_q <= lo_a;
      for (int i = 0; i < 3; i++) gap_q[i] <= hi_a[i] ? 5'h00 : gap_q[i] + {4'h0, gap_q[i] != 5'h1f};
    end
  end
  sequence s_refresh;
    $rose(all_lo) && backward_rotation_flag_out && quiet_q >= 10'h12c;
  endsequence
  sequence s_wr_take;
    aw_tk && w_tk;
  endsequence
  AST_NO_SHOOT: assert property ((settle_q == 3'h0) |-> ((hi_a & lo_a) == 3'h0))
    else $error("high and low side of one phase both active");
  AST_DEAD_GAP: assert property ((settle_q == 3'h0) |-> (short_gap == 3'h0))
    else $error("low side turned on before dead time elapsed");
  AST_FAULT_OFF: assert property ((bad_q >= 6'h32 && settle_q == 3'h0) |-> (act == 6'h00))
    else $error("gates active during invalid hall pattern");
  AST_BWD_START: assert property ($rose(resetn_in) |-> backward_rotation_flag_out)
    else $error("backward flag low right after reset");
  AST_CARRIER: assert property (s_refresh |-> ##252 ($rose(all_lo) || quiet_q < 10'h12c))
    else $error("refresh pulse not repeated one carrier later");
  AST_WR_RESP: assert property (s_wr_take |=> !axi_rsp_out.bvalid ##1 axi_rsp_out.bvalid)
    else $error("write response not two cycles after acceptance");
  AST_B_HOLD: assert property (axi_rsp_out.bvalid && !axi_req_in.bready |=>
      axi_rsp_out.bvalid && $stable(axi_rsp_out.bresp))
    else $error("write response dropped before bready");
  AST_RD_RESP: assert property (ar_tk |=> axi_rsp_out.rvalid &&
      axi_rsp_out.rresp == ($past(ar_bad) ? 2'h3 : 2'h0))
    else $error("read answer late or wrong code");
  AST_R_HOLD: assert property (axi_rsp_out.rvalid && !axi_req_in.rready |=>
      axi_rsp_out.rvalid && $stable(axi_rsp_out.rdata))
    else $error("read data changed before rready");
endmodule // hsp_mod_checker

bind hsp_modulator hsp_mod_checker #(.SLOW_LIMIT(SLOW_LIMIT), .CNT_W(CNT_W)) u_chk (
  .clk_in(clk_in), .resetn_in(resetn_in), .hall_sense_a_in(hall_sense_a_in),
  .hall_sense_b_in(hall_sense_b_in), .hall_sense_c_in(hall_sense_c_in),
  .axi_req_in(axi_req_in), .axi_rsp_out(axi_rsp_out), .gates_out(gates_out),
  .backward_rotation_flag_out(backward_rotation_flag_out));

// file: hsp_hall_model.sv
`timescale 1ns/1ps
module hsp_hall_model (
  input  wire logic        clk_in,
  input  wire logic        run_in,
  input  wire logic        back_in,
  input  wire logic [15:0] period_in,
  input  wire logic        force_in,
  input  wire logic [2:0]  force_val_in,
  output logic [2:0]       hall_out
);
  // forward order of {c,b,a}; back_in walks it the other way
  localparam logic [2:0] SEQ [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  int idx = 0;
  int cnt = 0;
  always @(posedge clk_in) begin
    if (run_in) begin
      if (cnt + 1 >= int'(period_in)) begin
        cnt <= 0;
        idx <= back_in ? (idx + 5) % 6 : (idx + 1) % 6;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
  assign hall_out = force_in ? force_val_in : SEQ[idx];
endmodule // hsp_hall_model

// file: hall_sine_pwm_modulator_tb.sv
`timescale 1ns/1ps
module hall_sine_pwm_modulator_tb import hsp_pkg::*;;
  logic         clk_in, resetn_in, bwd, run, back, frc;
  logic [15:0]  period;
  logic [2:0]   frc_val, hall;
  logic [31:0]  d;
  hsp_axi_req_t req;
  hsp_axi_rsp_t rsp;
  hsp_gates_t   gates;
  int           err_total = 0;
  int           cmp_count = 0;
  int           hi_c [3];
  int           allo_c, h40, hff, hmid, nph;
  hsp_modulator #(.SLOW_LIMIT(2048), .CNT_W(20)) DUT (.clk_in(clk_in), .resetn_in(resetn_in),
    .hall_sense_a_in(hall[0]), .hall_sense_b_in(hall[1]), .hall_sense_c_in(hall[2]),
    .axi_req_in(req), .axi_rsp_out(rsp), .gates_out(gates), .backward_rotation_flag_out(bwd));
  hsp_hall_model u_hall (.clk_in(clk_in), .run_in(run), .back_in(back), .period_in(period),
    .force_in(frc), .force_val_in(frc_val), .hall_out(hall));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
    logic [1:0] r;
    r = 2'h2;
    @(posedge clk_in);
    req.awaddr <= a; req.wdata <= v; req.wstrb <= 4'hf;
    req.awvalid <= 1'b1; req.wvalid <= 1'b1; req.bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk_in);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) begin
        r = rsp.bresp;
        req.bready <= 1'b0;
        break;
      end
    end
    check({30'h0, r}, {30'h0, er}, "bresp");
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] v, input logic [1:0] er);
    logic [1:0] r;
    r = 2'h2;
    v = 32'h0;
    @(posedge clk_in);
    req.araddr <= a; req.arvalid <= 1'b1; req.rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk_in);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) begin
        r = rsp.rresp;
        v = rsp.rdata;
        req.rready <= 1'b0;
        break;
      end
    end
    check({30'h0, r}, {30'h0, er}, "rresp");
  endtask
  // gates counted as active high; callers keep polarity at 1 here
  task automatic meas(input int n);
    hi_c = '{0, 0, 0};
    allo_c = 0;
    nph = 0;
    for (int k = 0; k < n; k++) begin
      @(posedge clk_in);
      for (int p = 0; p < 3; p++) hi_c[p] += (gates.high[p] === 1'b1);
      allo_c += (gates.low === 3'h7);
    end
    for (int p = 0; p < 3; p++) nph += (hi_c[p] > 0);
  endtask
  // phases sum to a constant, so amplitude shows only as spread between them
  function automatic int spread();
    int mx;
    int mn;
    mx = hi_c[0];
    mn = hi_c[0];
    for (int p = 1; p < 3; p++) begin
      if (hi_c[p] > mx) mx = hi_c[p];
      if (hi_c[p] < mn) mn = hi_c[p];
    end
    return mx - mn;
  endfunction
  task automatic ctl(input logic [31:0] v, input int settle);
    wr(32'h0, v, 2'h0);
    repeat (settle) @(posedge clk_in);
  endtask
  initial begin
    #(25 * 90000);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
  initial begin
    req = '0; resetn_in = 1'b0; run = 1'b0; back = 1'b0; frc = 1'b0;
    frc_val = 3'h0; period = 16'd600;
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(32'h0, d, 2'h0);
    check(d, 32'h0000_0600, "ctrl reset");
    rd(32'h4, d, 2'h0);
    check({29'h0, d[2:0]}, 32'h1, "status after reset");
    rd(32'h40, d, 2'h3);
    wr(32'h44, 32'hffff_ffff, 2'h3);
    wr(32'h4, 32'h0, 2'h0);
    $display("test registers done");
    ctl(32'h600, 300);
    meas(1008);
    check(hi_c[0] + hi_c[1] + hi_c[2], 0, "high on at zero amplitude");
    check(allo_c, 4 * (252 * 8 / 100), "refresh width");
    ctl(32'h640, 300);
    meas(1008);
    h40 = hi_c[0] + hi_c[1] + hi_c[2];
    ctl(32'h6ff, 300);
    meas(1008);
    hff = hi_c[0] + hi_c[1] + hi_c[2];
    check({31'h0, h40 > 0 && h40 < hff}, 32'h1, "duty follows amplitude");
    check({31'h0, hff <= 4 * (231 - 2 * 11)}, 32'h1, "on time cap");
    check(allo_c, 4 * (252 * 8 / 100), "refresh width at full amplitude");
    check(nph, 1, "one high phase conducting");
    check({31'h0, bwd}, 32'h1, "square while stopped");
    $display("test square drive done");
    frc <= 1'b1;
    frc_val <= 3'h7;
    repeat (80) @(posedge clk_in);
    check({26'h0, gates}, 32'h0, "all high halls");
    ctl(32'h080, 80);
    check({26'h0, gates}, 32'h3f, "active low off level");
    frc_val <= 3'h0;
    repeat (80) @(posedge clk_in);
    check({26'h0, gates}, 32'h3f, "all low halls");
    ctl(32'h480, 80);
    check({26'h0, gates}, 32'h0, "active high off level");
    frc <= 1'b0;
    $display("test hall fault done");
    run <= 1'b1;
    repeat (7200) @(posedge clk_in);
    check({31'h0, bwd}, 32'h0, "sine when fast forward");
    rd(32'h4, d, 2'h0);
    check({29'h0, d[2:0]}, 32'h4, "status sine");
    rd(32'h8, d, 2'h0);
    check({31'h0, d >= 598 && d <= 602}, 32'h1, "interval count");
    meas(3600);
    check(nph, 3, "all phases conduct high");
    meas(252);
    hmid = spread();
    ctl(32'h420, 300);
    meas(252);
    check({31'h0, spread() < hmid}, 32'h1, "sine amplitude");
    $display("test sine drive done");
    ctl(32'h580, 1800);
    check({31'h0, bwd}, 32'h1, "direction mismatch");
    back <= 1'b1;
    repeat (3600) @(posedge clk_in);
    check({31'h0, bwd}, 32'h0, "reverse matches select");
    back <= 1'b0;
    period <= 16'd3000;
    ctl(32'h480, 12000);
    check({31'h0, bwd}, 32'h1, "below start-up speed");
    $display("test direction and speed done");
    print_verdict();
  end
endmodule // hall_sine_pwm_modulator_tb
